// [phy_cfg_pkg.sv]
// package of constants and types for the media and negotiation configuration block
package phy_cfg_pkg;
    localparam logic [4:0] ADDR_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h01;
    localparam logic [4:0] ADDR_ADVERT = 5'h04;
    localparam logic [4:0] ADDR_PARTNER = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_PHY_STATUS = 5'h10;
    localparam logic [4:0] ADDR_PCS = 5'h16;
    localparam int CTL_SPEED_BIT = 13;
    localparam int CTL_NEG_EN_BIT = 12;
    localparam int CTL_RESTART_BIT = 9;
    localparam int CTL_DUPLEX_BIT = 8;
    localparam int PCS_FIBER_BIT = 6;
    localparam int PCS_FEF_BIT = 3;
    localparam int PCS_SCR_BYP_BIT = 1;
    localparam int PCS_DESCR_BYP_BIT = 0;
    localparam logic [15:0] STATUS_FIXED = 16'h7849;
    localparam int STATUS_NEG_DONE_BIT = 5;
    localparam int STATUS_RFAULT_BIT = 4;
    localparam int STATUS_LINK_BIT = 2;
    localparam logic [15:0] ADVERT_BASE = 16'h0001;
    localparam logic [15:0] PD_PARTNER_100 = 16'h0081;
    localparam logic [15:0] PD_PARTNER_10 = 16'h0021;
    localparam logic [15:0] EXPANSION_LOCAL_NP = 16'h0004;
    localparam int CLOCK_HZ = 20000000;
    localparam int BREAK_LINK_MS = 1500;
    localparam int BREAK_LINK_CYCLES = (CLOCK_HZ / 1000) * BREAK_LINK_MS;
    typedef enum logic [1:0] {MODE_10_HALF, MODE_10_FULL, MODE_100_HALF, MODE_100_FULL} speed_mode_t;
    typedef enum {NEG_IDLE, NEG_BREAK, NEG_BURST, NEG_DONE} neg_state_t;
endpackage

// [strap_sync_if.sv]
// interface carrying the synchronised strap levels to the main block
`timescale 1ns/1ps
interface strap_sync_if;
    logic [3:0] level;
    modport source (output level);
    modport sink (input level);
endinterface

// [strap_sync.sv]
// two flip-flop synchroniser for the strap pins
`timescale 1ns/1ps
module strap_sync
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] pins,
    strap_sync_if.source out
);
    typedef struct packed
    {
        logic [3:0] first;
        logic [3:0] second;
    } sync_state_t;
    sync_state_t state;
    sync_state_t next_state;
    always_comb
    begin
        next_state.first = pins;
        next_state.second = state.first;
    end
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            state <= '0;
        else
            state <= next_state;
    end
    assign out.level = state.second;
endmodule // strap_sync

// [phy_media_autoneg_config.sv]
// media selection and negotiation configuration block with its management registers
`timescale 1ns/1ps
module phy_media_autoneg_config
#(
    parameter int BREAK_CYCLES = phy_cfg_pkg::BREAK_LINK_CYCLES
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic rx_error_strap,
    input wire logic negotiation_enable_strap,
    input wire logic negotiation_select_high_strap,
    input wire logic negotiation_select_low_strap,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic page_received,
    input wire logic [15:0] partner_word,
    input wire logic partner_next_page,
    input wire logic partner_is_negotiating,
    input wire logic parallel_link_100,
    input wire logic parallel_link_10,
    input wire logic link_up,
    output logic [15:0] reg_rdata,
    output logic flp_enable,
    output logic link_silent,
    output logic fiber_mode,
    output logic speed_100,
    output logic full_duplex
);
    import phy_cfg_pkg::*;

    // ****************************************
    // strap synchronisation
    // ****************************************
    strap_sync_if straps ();
    strap_sync u_strap_sync
    (
        .clock(clock),
        .resetn(resetn),
        .pins({rx_error_strap, negotiation_enable_strap, negotiation_select_high_strap,
               negotiation_select_low_strap}),
        .out(straps)
    );

    typedef struct packed
    {
        logic [1:0] warm;
        logic strapped;
        logic [15:0] control;
        logic [15:0] advert;
        logic [15:0] partner;
        logic [15:0] pcs;
        logic neg_done;
        logic page_flag;
        logic pd_fault;
        logic partner_np;
        logic partner_able;
        logic rfault_seen;
        logic [31:0] timer;
        neg_state_t neg;
        logic [1:0] mode;
        logic [15:0] rdata;
        logic flp;
        logic silent;
        logic spd;
        logic dup;
    } cfg_state_t;
    cfg_state_t state;
    cfg_state_t next_state;

    // ****************************************
    // priority resolution
    // ****************************************
    function automatic logic [1:0] resolve(input logic [15:0] ours, input logic [15:0] theirs);
        logic [15:0] common;
        common = ours & theirs;
        if (common[8])
            resolve = MODE_100_FULL;
        else if (common[7])
            resolve = MODE_100_HALF;
        else if (common[6])
            resolve = MODE_10_FULL;
        else
            resolve = MODE_10_HALF;
    endfunction

    logic fiber_strap;
    logic [1:0] sel;
    logic [3:0] adv_bits;
    logic wr_ctl;
    logic restart_req;
    logic [15:0] status_word;
    logic [15:0] phy_status_word;
    logic [15:0] expansion_word;

    always_comb
    begin
        fiber_strap = !straps.level[3];
        sel = straps.level[1:0];
        // advertised abilities, bits 8..5 = 100F,100H,10F,10H
        case ({straps.level[2], sel})
            3'b100: adv_bits = 4'h3;
            3'b101: adv_bits = 4'hC;
            3'b110: adv_bits = 4'h8;
            3'b111: adv_bits = 4'hF;
            default: adv_bits = 4'hF;
        endcase
        wr_ctl = reg_write && reg_addr == ADDR_CONTROL;
        restart_req = wr_ctl && reg_wdata[CTL_RESTART_BIT] && reg_wdata[CTL_NEG_EN_BIT];
        status_word = STATUS_FIXED;
        status_word[STATUS_NEG_DONE_BIT] = state.neg_done;
        status_word[STATUS_RFAULT_BIT] = state.rfault_seen;
        status_word[STATUS_LINK_BIT] = link_up;
        phy_status_word = 16'h0000;
        phy_status_word[0] = link_up;
        phy_status_word[1] = link_up && !speed_100_now(state);
        phy_status_word[2] = link_up && full_now(state);
        phy_status_word[4] = state.neg_done;
        expansion_word = EXPANSION_LOCAL_NP;
        expansion_word[4] = state.pd_fault;
        expansion_word[3] = state.partner_np;
        expansion_word[1] = state.page_flag;
        expansion_word[0] = state.partner_able;
    end

    function automatic logic speed_100_now(input cfg_state_t s);
        if (s.control[CTL_NEG_EN_BIT])
            speed_100_now = s.mode[1];
        else
            speed_100_now = s.control[CTL_SPEED_BIT];
    endfunction

    function automatic logic full_now(input cfg_state_t s);
        if (s.control[CTL_NEG_EN_BIT])
            full_now = s.mode[0];
        else
            full_now = s.control[CTL_DUPLEX_BIT];
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_state.rdata = 16'h0000;
        // straps settle through the synchroniser, then are taken once
        if (state.warm != 2'h3)
            next_state.warm = state.warm + 2'h1;
        if (state.warm == 2'h3 && !state.strapped)
        begin
            next_state.strapped = 1'b1;
            next_state.pcs[PCS_FIBER_BIT] = fiber_strap;
            next_state.pcs[PCS_FEF_BIT] = fiber_strap;
            next_state.pcs[PCS_SCR_BYP_BIT] = fiber_strap;
            next_state.pcs[PCS_DESCR_BYP_BIT] = fiber_strap;
            next_state.advert[8:5] = adv_bits;
            next_state.control[CTL_NEG_EN_BIT] = straps.level[2];
            next_state.control[CTL_SPEED_BIT] = sel[1];
            next_state.control[CTL_DUPLEX_BIT] = sel[0];
            next_state.neg = straps.level[2] ? NEG_BURST : NEG_IDLE;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                ADDR_CONTROL:
                begin
                    next_state.control = reg_wdata & 16'hFFFF;
                    next_state.control[CTL_RESTART_BIT] = 1'b0;
                    if (!reg_wdata[CTL_NEG_EN_BIT])
                    begin
                        next_state.neg = NEG_IDLE;
                        next_state.neg_done = 1'b0;
                    end
                    else if (!state.control[CTL_NEG_EN_BIT])
                        next_state.neg = NEG_BURST;
                end
                ADDR_ADVERT: next_state.advert = reg_wdata;
                ADDR_PCS: next_state.pcs = reg_wdata;
                default: next_state.control = state.control;
            endcase
        end
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_CONTROL: next_state.rdata = state.control;
                ADDR_STATUS: next_state.rdata = status_word;
                ADDR_ADVERT: next_state.rdata = state.advert;
                ADDR_PARTNER: next_state.rdata = state.partner;
                ADDR_EXPANSION: next_state.rdata = expansion_word;
                ADDR_PHY_STATUS: next_state.rdata = phy_status_word;
                ADDR_PCS: next_state.rdata = state.pcs;
                default: next_state.rdata = 16'h0000;
            endcase
            if (reg_addr == ADDR_EXPANSION)
                next_state.page_flag = 1'b0;
        end
        // ****************************************
        // negotiation sequencing
        // ****************************************
        case (state.neg)
            NEG_IDLE:
                next_state.timer = 32'h0;
            NEG_BREAK:
            begin
                next_state.timer = state.timer + 32'h1;
                if (state.timer >= 32'(BREAK_CYCLES - 1))
                    next_state.neg = NEG_BURST;
            end
            NEG_BURST:
            begin
                if (page_received)
                begin
                    next_state.partner = partner_word;
                    next_state.partner_np = partner_next_page;
                    next_state.partner_able = 1'b1;
                    next_state.rfault_seen = partner_word[13];
                    if (!partner_next_page)
                    begin
                        next_state.mode = resolve(state.advert, partner_word);
                        next_state.neg = NEG_DONE;
                        next_state.neg_done = 1'b1;
                    end
                end
                else if (!partner_is_negotiating && (parallel_link_100 ^ parallel_link_10))
                begin
                    next_state.partner = parallel_link_100 ? PD_PARTNER_100 : PD_PARTNER_10;
                    next_state.partner_able = 1'b0;
                    next_state.mode = parallel_link_100 ? MODE_100_HALF : MODE_10_HALF;
                    next_state.neg = NEG_DONE;
                    next_state.neg_done = 1'b1;
                end
                else if (!partner_is_negotiating && parallel_link_100 && parallel_link_10)
                    next_state.pd_fault = 1'b1;
            end
            NEG_DONE:
                if (!link_up)
                begin
                    next_state.neg = NEG_BURST;
                    next_state.neg_done = 1'b0;
                end
            default:
                next_state.neg = NEG_IDLE;
        endcase
        // set of the page flag wins over the clearing read
        if (page_received && state.neg == NEG_BURST)
            next_state.page_flag = 1'b1;
        // a cleared enable bit parks the sequencer whatever the link does
        if (!next_state.control[CTL_NEG_EN_BIT])
        begin
            next_state.neg = NEG_IDLE;
            next_state.neg_done = 1'b0;
        end
        if (restart_req && state.control[CTL_NEG_EN_BIT])
        begin
            next_state.neg = NEG_BREAK;
            next_state.timer = 32'h0;
            next_state.neg_done = 1'b0;
        end
        next_state.flp = next_state.neg == NEG_BURST;
        next_state.silent = next_state.neg == NEG_BREAK;
        // speed and duplex leave through their own flops
        next_state.spd = speed_100_now(next_state);
        next_state.dup = full_now(next_state);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= '0;
            state.advert <= ADVERT_BASE | 16'h01E0;
            state.control <= 16'h0000;
            state.neg <= NEG_IDLE;
        end
        else
            state <= next_state;
    end

    assign reg_rdata = state.rdata;
    assign flp_enable = state.flp;
    assign link_silent = state.silent;
    assign fiber_mode = state.pcs[PCS_FIBER_BIT];
    assign speed_100 = state.spd;
    assign full_duplex = state.dup;

    // ****************************************
    // assertions
    // ****************************************
    sequence restart_seq;
        restart_req && state.control[CTL_NEG_EN_BIT];
    endsequence
    AST_RESTART_SILENCE: assert property (@(posedge clock) disable iff (!resetn)
        restart_seq |=> link_silent && !flp_enable) else $error("restart did not silence link");
    AST_PD_100: assert property (@(posedge clock) disable iff (!resetn)
        state.neg == NEG_BURST && !page_received && !partner_is_negotiating && parallel_link_100
        && !parallel_link_10 && !restart_req |=> state.partner == PD_PARTNER_100)
        else $error("parallel detect 100 value wrong");
    AST_STATUS_FIXED: assert property (@(posedge clock) disable iff (!resetn)
        reg_read && reg_addr == ADDR_STATUS |=> reg_rdata[15] == 1'b0 && reg_rdata[14:11] == 4'hF)
        else $error("status ability bits wrong");
    AST_FORCED_SPEED: assert property (@(posedge clock) disable iff (!resetn)
        !state.control[CTL_NEG_EN_BIT] |-> speed_100 == state.control[CTL_SPEED_BIT])
        else $error("forced speed not followed");
    AST_FIBER_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        state.strapped && reg_write && reg_addr == ADDR_PCS |=> fiber_mode == $past(reg_wdata[PCS_FIBER_BIT]))
        else $error("fiber bit write lost");
    AST_STRAP_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        state.strapped |=> state.strapped) else $error("strap latch repeated");
    AST_PARTNER_CAPTURE: assert property (@(posedge clock) disable iff (!resetn)
        state.neg == NEG_BURST && page_received |=> state.partner == $past(partner_word))
        else $error("partner word not captured");
    AST_BREAK_BOUNDED: assert property (@(posedge clock) disable iff (!resetn)
        link_silent |-> state.timer < 32'(BREAK_CYCLES)) else $error("break timer overran");
    AST_RESTART_CLEARS: assert property (@(posedge clock) disable iff (!resetn)
        restart_seq |=> !state.control[CTL_RESTART_BIT]) else $error("restart bit did not clear");

    // ****************************************
    // strap, link-side and read-back assertions
    // ****************************************
    sequence break_end_seq;
        link_silent && state.timer == 32'(BREAK_CYCLES - 1) && !wr_ctl;
    endsequence
    AST_BREAK_END: assert property (@(posedge clock) disable iff (!resetn)
        break_end_seq |=> flp_enable && !link_silent) else $error("bursts did not resume after break");
    sequence strap_take_seq;
        state.warm == 2'h3 && !state.strapped;
    endsequence
    AST_STRAP_MEDIUM: assert property (@(posedge clock) disable iff (!resetn)
        strap_take_seq |=> fiber_mode == !$past(straps.level[3])) else $error("strapped medium wrong");
    AST_ADVERT_STRAP: assert property (@(posedge clock) disable iff (!resetn)
        state.warm == 2'h3 && !state.strapped && straps.level[2:0] == 3'b110
        |=> state.advert[8:5] == 4'h8) else $error("strapped advertisement wrong");
    AST_PD_10: assert property (@(posedge clock) disable iff (!resetn)
        state.neg == NEG_BURST && !page_received && !partner_is_negotiating && parallel_link_10
        && !parallel_link_100 |=> state.partner == PD_PARTNER_10) else $error("parallel detect 10 value wrong");
    AST_PAGE_FLAG: assert property (@(posedge clock) disable iff (!resetn)
        state.neg == NEG_BURST && page_received |=> state.page_flag) else $error("page flag not set");
    AST_STATUS_LIVE: assert property (@(posedge clock) disable iff (!resetn)
        reg_read && reg_addr == ADDR_STATUS |=> reg_rdata[STATUS_NEG_DONE_BIT] == $past(state.neg_done)
        && reg_rdata[STATUS_LINK_BIT] == $past(link_up)) else $error("status live bits wrong");
    AST_DISABLE_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        state.strapped && wr_ctl && !reg_wdata[CTL_NEG_EN_BIT] |=> !flp_enable && !link_silent)
        else $error("disable did not stop negotiation");
    AST_PHY_STATUS: assert property (@(posedge clock) disable iff (!resetn)
        reg_read && reg_addr == ADDR_PHY_STATUS && link_up |=> reg_rdata[1] == !$past(speed_100)
        && reg_rdata[2] == $past(full_duplex)) else $error("phy status speed or duplex wrong");
    AST_EXPANSION_FIXED: assert property (@(posedge clock) disable iff (!resetn)
        reg_read && reg_addr == ADDR_EXPANSION |=> reg_rdata[2] == 1'b1 && reg_rdata[15:5] == 11'h000)
        else $error("expansion fixed bits wrong");
endmodule // phy_media_autoneg_config

// [link_partner_model.sv]
// behavioural link partner driving the receive-side inputs of the block
`timescale 1ns/1ps
module link_partner_model
(
    input wire logic clock,
    output logic page_received,
    output logic [15:0] partner_word,
    output logic partner_next_page,
    output logic partner_is_negotiating,
    output logic parallel_link_100,
    output logic parallel_link_10,
    output logic link_up
);
    initial
    begin
        page_received = 1'b0;
        partner_word = 16'hA5A5;
        partner_next_page = 1'b0;
        partner_is_negotiating = 1'b0;
        parallel_link_100 = 1'b0;
        parallel_link_10 = 1'b0;
        link_up = 1'b0;
    end
    // a one-cycle link drop reopens a finished negotiation, then one code word
    // is held for one edge; the bus then shows the inverse
    task automatic send_page(input logic [15:0] w);
        @(posedge clock);
        #1;
        link_up = 1'b0;
        @(posedge clock);
        #1;
        partner_word = w;
        page_received = 1'b1;
        partner_is_negotiating = 1'b1;
        link_up = 1'b1;
        @(posedge clock);
        #1;
        page_received = 1'b0;
        partner_word = ~w;
    endtask
    // non-negotiating partner with a plain link signal
    task automatic par_link(input logic is100);
        @(posedge clock);
        #1;
        partner_is_negotiating = 1'b0;
        parallel_link_100 = is100;
        parallel_link_10 = !is100;
        link_up = 1'b1;
    endtask
endmodule // link_partner_model

// [tb_phy_media_autoneg_config.sv]
// self-checking testbench for the media and negotiation configuration block
`timescale 1ns/1ps
module tb_phy_media_autoneg_config;
    import phy_cfg_pkg::*;
    localparam int BRK = 20;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic rx_err = 1'b1, nen = 1'b1, shi = 1'b1, slo = 1'b1;
    logic reg_write = 1'b0, reg_read = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd, pw;
    logic page_received, partner_next_page, partner_is_negotiating;
    logic parallel_link_100, parallel_link_10, link_up;
    logic flp_enable, link_silent, fiber_mode, speed_100, full_duplex;
    int n_fail = 0, total_checks = 0, cycles = 0;
    always #25 clock = ~clock;
    phy_media_autoneg_config #(.BREAK_CYCLES(BRK)) dut_u (.clock(clock), .resetn(resetn),
        .rx_error_strap(rx_err), .negotiation_enable_strap(nen), .negotiation_select_high_strap(shi),
        .negotiation_select_low_strap(slo), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .page_received(page_received),
        .partner_word(pw), .partner_next_page(partner_next_page),
        .partner_is_negotiating(partner_is_negotiating), .parallel_link_100(parallel_link_100),
        .parallel_link_10(parallel_link_10), .link_up(link_up), .reg_rdata(reg_rdata),
        .flp_enable(flp_enable), .link_silent(link_silent), .fiber_mode(fiber_mode),
        .speed_100(speed_100), .full_duplex(full_duplex));
    link_partner_model partner_u (.clock(clock), .page_received(page_received), .partner_word(pw),
        .partner_next_page(partner_next_page), .partner_is_negotiating(partner_is_negotiating),
        .parallel_link_100(parallel_link_100), .parallel_link_10(parallel_link_10), .link_up(link_up));
    // ****************
    // helpers
    // ****************
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        #1;
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_write = 1'b0;
    endtask
    task automatic rdr(input logic [4:0] a);
        @(posedge clock);
        #1;
        reg_read = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1;
        rd = reg_rdata;
        reg_read = 1'b0;
    endtask
    task automatic do_reset(input logic [3:0] s);
        @(posedge clock);
        #1;
        {rx_err, nen, shi, slo} = s;
        resetn = 1'b0;
        repeat (16) @(posedge clock);
        #1;
        resetn = 1'b1;
        repeat (6) @(posedge clock);
        #1;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_fiber_status;
        do_reset(4'b0111);
        rdr(ADDR_PCS);
        check(rd & 16'h004B, 16'h004B);
        check(16'(fiber_mode), 16'h0001);
        rdr(ADDR_STATUS);
        check(rd & 16'hF849, 16'h7849);
        rdr(ADDR_EXPANSION);
        check(rd & 16'h0004, 16'h0004);
        rdr(5'h1F);
        check(rd, 16'h0000);
        wr(ADDR_PCS, 16'h000B);
        check(16'(fiber_mode), 16'h0000);
        wr(ADDR_PCS, 16'h0040);
        check(16'(fiber_mode), 16'h0001);
    endtask
    task automatic t_resolve;
        logic [15:0] w[5] = '{16'h01E1, 16'h00A1, 16'h0061, 16'h0021, 16'h21E1};
        logic [1:0] m[5] = '{2'b11, 2'b10, 2'b01, 2'b00, 2'b01};
        for (int i = 0; i < 5; i++)
        begin
            if (i == 4)
                wr(ADDR_ADVERT, 16'h0061);
            partner_u.send_page(w[i]);
            repeat (4) @(posedge clock);
            rdr(ADDR_PARTNER);
            check(rd, w[i]);
            check({14'h0, speed_100, full_duplex}, {14'h0, m[i]});
            rdr(ADDR_PHY_STATUS);
            check(rd & 16'h0007, {13'h0, m[i][0], !m[i][1], 1'b1});
        end
        rdr(ADDR_STATUS);
        check(rd & 16'h0034, 16'h0034);
        rdr(ADDR_EXPANSION);
        check(rd & 16'h000B, 16'h0003);
        rdr(ADDR_EXPANSION);
        check(rd & 16'h0002, 16'h0000);
    endtask
    task automatic t_restart_parallel;
        int n;
        n = 0;
        wr(ADDR_CONTROL, 16'h1200);
        while (link_silent === 1'b1 && n < 100)
        begin
            check(16'(flp_enable), 16'h0000);
            n++;
            @(posedge clock);
            #1;
        end
        check(16'(n), 16'(BRK));
        check(16'(flp_enable), 16'h0001);
        rdr(ADDR_CONTROL);
        check(rd & 16'h0200, 16'h0000);
        partner_u.par_link(1'b1);
        repeat (4) @(posedge clock);
        rdr(ADDR_PARTNER);
        check(rd, 16'h0081);
        check({speed_100, full_duplex}, 2'b10);
        rdr(ADDR_EXPANSION);
        check(rd & 16'h0001, 16'h0000);
        wr(ADDR_CONTROL, 16'h2000);
        check({speed_100, full_duplex}, 2'b10);
        wr(ADDR_CONTROL, 16'h0100);
        check({speed_100, full_duplex}, 2'b01);
    endtask
    task automatic t_straps;
        logic [15:0] adv[4] = '{16'h0060, 16'h0180, 16'h0100, 16'h01E0};
        for (int i = 0; i < 8; i++)
        begin
            do_reset({1'b1, 3'(i)});
            check(16'(fiber_mode), 16'h0000);
            rdr(ADDR_CONTROL);
            if (nen)
                check(rd & 16'h1000, 16'h1000);
            else
            begin
                check(rd & 16'h3100, (shi ? 16'h2000 : 16'h0) | (slo ? 16'h0100 : 16'h0));
                check({speed_100, full_duplex}, {shi, slo});
            end
            rdr(ADDR_ADVERT);
            check(rd & 16'h01E0, nen ? adv[i % 4] : 16'h01E0);
            {nen, shi, slo} = ~{nen, shi, slo};
            repeat (8) @(posedge clock);
            rdr(ADDR_ADVERT);
            check(rd & 16'h01E0, (i > 3) ? adv[i % 4] : 16'h01E0);
        end
    endtask
    task automatic t_forced_enable;
        int n;
        n = 0;
        do_reset(4'b1011);
        check(16'(flp_enable), 16'h0000);
        partner_u.par_link(1'b0);
        wr(ADDR_CONTROL, 16'h0000);
        wr(ADDR_CONTROL, 16'h1000);
        while (flp_enable !== 1'b1 && n < 100)
        begin
            n++;
            @(posedge clock);
            #1;
        end
        check(16'(flp_enable), 16'h0001);
        repeat (2) @(posedge clock);
        rdr(ADDR_PARTNER);
        check(rd, 16'h0021);
        check({speed_100, full_duplex}, 2'b00);
    endtask
    initial
    begin
        t_fiber_status();
        t_resolve();
        t_restart_parallel();
        t_straps();
        t_forced_enable();
        give_verdict();
    end
endmodule // tb_phy_media_autoneg_config
